//--- comm_otp_fault_map.svh
`ifndef COMM_OTP_FAULT_MAP_SVH
`define COMM_OTP_FAULT_MAP_SVH

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define IDX_HOST_UART      14'h0530
`define IDX_DAISY_PORT     14'h0531
`define IDX_STACK_LINK     14'h0532
`define IDX_CONFIG_LOAD    14'h0535
`define IDX_SUMMARY        14'h052D
`define IDX_CLEAR_CMD      14'h0332
`define IDX_LINK_CTRL      14'h0400
`define IDX_COMM_MASK      14'h0401

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define HU_RESP_TX         4
`define HU_RESP_RX         3
`define HU_CMD_RX          2
`define HU_LINK_CLEAR      1
`define HU_STOP            0
`define SL_STACK_FAULT     3
`define SL_TONE            2
`define SL_HB_MISSING      1
`define SL_HEARTBEAT_TOO_FAST         0
`define CL_DOUBLE          6
`define CL_SINGLE          5
`define CL_USER_CRC        4
`define CL_FACTORY_SPACE_CHECKSUM_ERROR        3
`define CL_USER_LOAD       2
`define CL_FACT_LOAD       1
`define CL_OVERVOLT        0
`define CC_CRC             6
`define CC_DATA            5
`define CC_STACK           4
`define CC_TONE            3
`define CC_HB              2
`define CC_PORT            1
`define CC_UART            0
`define SUM_COMM           4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_FLAGS          8'h00
`define RST_DIR_SEL        1'b0
`define RST_MASK           5'h00

// ------------------------------------------------------------
// heartbeat timing, ns and clock
// ------------------------------------------------------------
`define CLK_NS             20
`define HB_MIN_NS          100000
`define HB_MAX_NS          2000000
`define HB_MIN_CYC         ((`HB_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define HB_MAX_CYC         (`HB_MAX_NS / `CLK_NS)

`endif

//--- comm_otp_fault_pkg.sv
package comm_otp_fault_pkg;

    typedef enum logic [1:0] {
        MODE_SHUTDOWN,
        MODE_SLEEP,
        MODE_ACTIVE
    } power_mode_e;

    typedef struct packed {
        logic resp_tx_fault;
        logic resp_rx_fault;
        logic cmd_rx_fault;
        logic uart_clear;
        logic sleep_wake_ping;
        logic wake_pulse;
        logic unexpected_stop;
    } host_events_s;

    typedef struct packed {
        logic tx_fault;
        logic resp_rx_fault;
        logic cmd_rx_fault;
        logic bit_fault;
    } port_events_s;

    typedef struct packed {
        logic heartbeat;
        logic alarm_tone;
    } supervision_s;

    typedef struct packed {
        logic any_programmed;
        logic page_format_error;
        logic program_attempted;
        logic program_succeeded;
        logic page_load_error;
    } page_status_s;

    typedef struct packed {
        logic         load_done;
        logic         double_bit;
        logic         single_bit;
        logic         user_crc_fail;
        logic         factory_space_checksum_error_fail;
        page_status_s user_page;
        page_status_s fact_page;
        logic         any_page_ov;
        logic         program_done;
    } load_result_s;

endpackage

//--- comm_otp_fault_status.sv
// Notes on behaviour
// [R1] response transmit uart fault sets flag
// [R2] response receive uart fault sets flag
// [R3] command receive uart fault sets flag
// [R4] clear signal, ping or wake sets flag
// [R5] unexpected stop or active ping sets flag
// [R6] upstream fault status bits set flag
// [R7] late heartbeat sets missing flag
// [R8] early heartbeat sets too-fast flag
// [R9] direction bit picks lower or upper port
// [R10] early alarm tone sets too-fast flag
// [R11] double-bit load error sets flag
// [R12] single-bit corrected error sets flag
// [R13] user space checksum failure sets flag
// [R14] factory space checksum failure sets flag
// [R15] user page load problems set flag
// [R16] factory page load problems set flag
// [R17] any page overvoltage sets global flag
// [R18] data clear leaves load flags alone
// [R19] new programming re-evaluates overvoltage flag
// [R20] host distrusts data while load flags set
// [R21] checksum clear bit clears checksum flags
// [R22] data clear bit clears bit-error flags
// [R23] port clear bit zeroes port faults
// [R24] unmasked comm flags drive summary bit
// [R25] port register bit order lower then upper
// [R26] flags sticky until clear or reset
`timescale 1ns/1ps
`include "comm_otp_fault_map.svh"

module comm_otp_fault_status #(
    parameter int unsigned HB_MIN = `HB_MIN_CYC,
    parameter int unsigned HB_MAX = `HB_MAX_CYC
) (
    input  wire logic                              clock,
    input  wire logic                              resetn,
    input  wire logic                              awvalid,
    output wire logic                              awready,
    input  wire logic [15:0]                       awaddr,
    input  wire logic                              wvalid,
    output wire logic                              wready,
    input  wire logic [31:0]                       wdata,
    input  wire logic [3:0]                        wstrb,
    output wire logic                              bvalid,
    input  wire logic                              bready,
    output wire logic [1:0]                        bresp,
    input  wire logic                              arvalid,
    output wire logic                              arready,
    input  wire logic [15:0]                       araddr,
    output wire logic                              rvalid,
    input  wire logic                              rready,
    output wire logic [31:0]                       rdata,
    output wire logic [1:0]                        rresp,
    input  wire comm_otp_fault_pkg::power_mode_e   power_mode,
    input  wire comm_otp_fault_pkg::host_events_s  host_ev,
    input  wire comm_otp_fault_pkg::port_events_s  lower_ev,
    input  wire comm_otp_fault_pkg::port_events_s  upper_ev,
    input  wire logic                              frame_rx_done,
    input  wire logic                              frame_fault_bits,
    input  wire comm_otp_fault_pkg::supervision_s  lower_sup,
    input  wire comm_otp_fault_pkg::supervision_s  upper_sup,
    input  wire comm_otp_fault_pkg::load_result_s  load_res,
    input  wire logic                              hardware_reset_request,
    output wire logic                              comm_fault_summary
);
    import comm_otp_fault_pkg::*;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [13:0] index_of(input logic [15:0] a);
        index_of = a[15:2];
    endfunction

    function automatic logic is_mapped(input logic [15:0] a);
        logic [13:0] i;
        i = a[15:2];
        is_mapped = (a[1:0] == 2'h0) &&
            (i == `IDX_HOST_UART || i == `IDX_DAISY_PORT ||
             i == `IDX_STACK_LINK || i == `IDX_CONFIG_LOAD ||
             i == `IDX_SUMMARY || i == `IDX_CLEAR_CMD ||
             i == `IDX_LINK_CTRL || i == `IDX_COMM_MASK);
    endfunction

    function automatic logic page_bad(input page_status_s p);
        page_bad = !p.any_programmed || p.page_format_error ||
            (p.program_attempted && !p.program_succeeded) ||
            p.page_load_error;
    endfunction

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic        aw_q, w_q, bvalid_q, rvalid_q;
    logic [15:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q, rresp_q;

    wire aw_fire = awvalid && awready;
    wire w_fire  = wvalid && wready;
    wire ar_fire = arvalid && arready;
    wire wr_go   = aw_q && w_q && !bvalid_q;
    wire [13:0] wr_idx = index_of(awaddr_q);
    wire wr_ok   = is_mapped(awaddr_q);
    wire wr_lane = wr_go && wr_ok && wstrb_q[0];
    wire [7:0] clr_cmd = (wr_lane && wr_idx == `IDX_CLEAR_CMD) ?
                         wdata_q[7:0] : 8'h00;
    wire wr_ctrl = wr_lane && wr_idx == `IDX_LINK_CTRL;
    wire wr_mask = wr_lane && wr_idx == `IDX_COMM_MASK;

    assign awready = !aw_q && !bvalid_q;
    assign wready  = !w_q && !bvalid_q;
    assign arready = !rvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= 16'h0000;
            wdata_q  <= 32'h00000000;
            wstrb_q  <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_q     <= 1'b1;
                awaddr_q <= awaddr;
            end else if (wr_go) begin
                aw_q <= 1'b0;
            end
            if (w_fire) begin
                w_q     <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end else if (wr_go) begin
                w_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= 2'h0;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? 2'h0 : 2'h2;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control and flag registers
    // ------------------------------------------------------------
    logic       dir_sel_q;
    logic [4:0] mask_q;
    logic [4:0] host_q;
    logic [7:0] port_q;
    logic [3:0] stack_q;
    logic [6:0] load_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dir_sel_q <= `RST_DIR_SEL;
            mask_q    <= `RST_MASK;
        end else begin
            if (wr_ctrl)
                dir_sel_q <= wdata_q[0];
            if (wr_mask)
                mask_q <= wdata_q[4:0];
        end
    end

    // [R9] port selection
    wire supervision_s sup = dir_sel_q ? upper_sup : lower_sup;

    // heartbeat supervision counter
    logic [20:0] hb_cnt_q;
    logic        hb_armed_q;
    wire hb_late  = hb_cnt_q == 21'(HB_MAX - 1) && !sup.heartbeat;
    wire hb_early = hb_armed_q && hb_cnt_q < 21'(HB_MIN);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hb_cnt_q   <= 21'h000000;
            hb_armed_q <= 1'b0;
        end else if (wr_ctrl) begin
            hb_cnt_q   <= 21'h000000;
            hb_armed_q <= 1'b0;
        end else if (sup.heartbeat) begin
            hb_cnt_q   <= 21'h000000;
            hb_armed_q <= 1'b1;
        end else if (hb_cnt_q < 21'(HB_MAX)) begin
            hb_cnt_q <= hb_cnt_q + 21'h000001;
        end
    end

    // [R4] clear detection sources
    wire link_clear_seen = host_ev.uart_clear ||
        (host_ev.sleep_wake_ping &&
         (power_mode == MODE_ACTIVE || power_mode == MODE_SLEEP)) ||
        (host_ev.wake_pulse && power_mode == MODE_ACTIVE);
    // [R5] stop detection sources
    wire unexpected_stop_seen = host_ev.unexpected_stop ||
        (host_ev.sleep_wake_ping && power_mode == MODE_ACTIVE);

    // [R1] [R2] [R3] host uart events
    wire [4:0] host_set = {host_ev.resp_tx_fault, host_ev.resp_rx_fault,
                           host_ev.cmd_rx_fault, link_clear_seen,
                           unexpected_stop_seen};
    // [R25] lower port in the upper nibble
    wire [7:0] port_set = {lower_ev, upper_ev};
    // [R6] [R7] [R8] [R10] stack link events
    wire [3:0] stack_set = {frame_rx_done && frame_fault_bits,
                            sup.alarm_tone, hb_late,
                            sup.heartbeat && hb_early ||
                            sup.alarm_tone && hb_early};
    wire [3:0] stack_clr = {clr_cmd[`CC_STACK], clr_cmd[`CC_TONE],
                            clr_cmd[`CC_HB], clr_cmd[`CC_HB]};

    // [R26] sticky, set wins over clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            host_q  <= 5'h00;
            port_q  <= `RST_FLAGS;
            stack_q <= 4'h0;
        end else begin
            host_q  <= host_set | (host_q & {5{!clr_cmd[`CC_UART]}});
            // [R23] port clear
            port_q  <= port_set | (port_q & {8{!clr_cmd[`CC_PORT]}});
            stack_q <= stack_set | (stack_q & ~stack_clr);
        end
    end

    // [R11] [R12] [R13] [R14] load result flags
    wire [3:0] data_set = load_res.load_done ?
        {load_res.double_bit, load_res.single_bit,
         load_res.user_crc_fail, load_res.factory_space_checksum_error_fail} : 4'h0;
    // [R21] [R22] separate checksum and data clears
    wire [3:0] data_clr = {clr_cmd[`CC_DATA], clr_cmd[`CC_DATA],
                           clr_cmd[`CC_CRC], clr_cmd[`CC_CRC]};
    // [R15] [R16] page load checks
    wire [1:0] ld_set = load_res.load_done ?
        {page_bad(load_res.user_page), page_bad(load_res.fact_page)} :
        2'h0;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            load_q <= 7'h00;
        end else begin
            load_q[6:3] <= data_set | (load_q[6:3] & ~data_clr);
            // [R18] only a device or hardware reset re-evaluates
            if (hardware_reset_request)
                load_q[2:1] <= 2'h0;
            else
                load_q[2:1] <= ld_set | load_q[2:1];
            // [R17] [R19] overvoltage evaluated on load or programming
            if (hardware_reset_request)
                load_q[0] <= 1'b0;
            else if (load_res.program_done)
                load_q[0] <= load_res.any_page_ov;
            else if (load_res.load_done && load_res.any_page_ov)
                load_q[0] <= 1'b1;
        end
    end

    // [R24] summary of unmasked communication groups
    wire summary = (!mask_q[0] && |host_q) || (!mask_q[1] && |port_q) ||
        (!mask_q[2] && |stack_q[1:0]) ||
        (!mask_q[3] && stack_q[`SL_TONE]) ||
        (!mask_q[4] && stack_q[`SL_STACK_FAULT]);
    assign comm_fault_summary = summary;

    // ------------------------------------------------------------
    // read path, reads leave every flag untouched
    // ------------------------------------------------------------
    wire [13:0] rd_idx = index_of(araddr);
    wire [7:0] rd_byte =
        rd_idx == `IDX_HOST_UART   ? {3'h0, host_q}     :
        rd_idx == `IDX_DAISY_PORT  ? port_q             :
        rd_idx == `IDX_STACK_LINK  ? {4'h0, stack_q}    :
        rd_idx == `IDX_CONFIG_LOAD ? {1'b0, load_q}     :
        rd_idx == `IDX_SUMMARY     ? {3'h0, summary, 4'h0} :
        rd_idx == `IDX_LINK_CTRL   ? {7'h00, dir_sel_q} :
        rd_idx == `IDX_COMM_MASK   ? {3'h0, mask_q}     : 8'h00;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= 2'h0;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= is_mapped(araddr) ? {24'h000000, rd_byte} :
                        32'h00000000;
            rresp_q  <= is_mapped(araddr) ? 2'h0 : 2'h2;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_resp_tx;
        host_ev.resp_tx_fault |=> host_q[`HU_RESP_TX];
    endproperty
    a_resp_tx: assert property (p_resp_tx) // [R1]
        else $error("transmit fault not flagged");

    property p_stop;
        host_ev.sleep_wake_ping && power_mode == MODE_ACTIVE
            |=> host_q[`HU_STOP] && host_q[`HU_LINK_CLEAR];
    endproperty
    a_stop: assert property (p_stop) // [R5]
        else $error("active ping missed stop or clear flag");

    property p_missing;
        !sup.heartbeat && !wr_ctrl && hb_cnt_q == 21'(HB_MAX - 1)
            |=> stack_q[`SL_HB_MISSING];
    endproperty
    a_missing: assert property (p_missing) // [R7]
        else $error("missing heartbeat not flagged");

    property p_fast;
        sup.heartbeat && hb_armed_q && hb_cnt_q < 21'(HB_MIN)
            |=> stack_q[`SL_HEARTBEAT_TOO_FAST];
    endproperty
    a_fast: assert property (p_fast) // [R8]
        else $error("early heartbeat not flagged");

    property p_sticky;
        port_q[7] && !clr_cmd[`CC_PORT] |=> port_q[7];
    endproperty
    a_sticky: assert property (p_sticky) // [R26]
        else $error("port flag dropped without clear");

    property p_port_clr;
        clr_cmd[`CC_PORT] && port_set == 8'h00 |=> port_q == 8'h00;
    endproperty
    a_port_clr: assert property (p_port_clr) // [R23]
        else $error("port clear left flags");

    property p_data_keeps_load;
        clr_cmd[`CC_DATA] && !hardware_reset_request &&
            !load_res.program_done && load_q[2]
            |=> load_q[2] && load_q[6:5] == $past(data_set[3:2]);
    endproperty
    a_data_keeps_load: assert property (p_data_keeps_load) // [R18]
        else $error("data clear touched load flag");

    property p_ov_reeval;
        load_res.program_done && !hardware_reset_request
            |=> load_q[0] == $past(load_res.any_page_ov);
    endproperty
    a_ov_reeval: assert property (p_ov_reeval) // [R19]
        else $error("overvoltage not re-evaluated");

    property p_summary;
        !mask_q[1] && |port_q |-> comm_fault_summary;
    endproperty
    a_summary: assert property (p_summary) // [R24]
        else $error("summary missed port fault");

endmodule

//--- stack_neighbour.sv
`timescale 1ns/1ps

// ----------------------------------------
// neighbour device: heartbeat and tone
// ----------------------------------------
module stack_neighbour (
    input  wire logic                            clock,
    input  wire logic                            resetn,
    input  wire logic                            lower_on,
    input  wire logic                            upper_on,
    input  wire logic                            tone_on,
    input  wire logic [7:0]                      hb_period,
    output wire comm_otp_fault_pkg::supervision_s lower_sup,
    output wire comm_otp_fault_pkg::supervision_s upper_sup
);
    import comm_otp_fault_pkg::*;
    logic [7:0] cnt_q;
    logic       beat_q;
    logic       tone_q;
    wire logic  beat_d;
    assign beat_d = (cnt_q >= hb_period - 8'h01);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_q  <= 8'h00;
            beat_q <= 1'h0;
            tone_q <= 1'h0;
        end else begin
            cnt_q  <= beat_d ? 8'h00 : cnt_q + 8'h01;
            beat_q <= beat_d;
            tone_q <= beat_q & tone_on;
        end
    end
    // tone trails the beat by one cycle, so it always counts as early
    assign lower_sup = '{heartbeat: beat_q & lower_on,
                         alarm_tone: tone_q & lower_on};
    assign upper_sup = '{heartbeat: beat_q & upper_on,
                         alarm_tone: tone_q & upper_on};
endmodule

//--- comm_otp_fault_status_test.sv
`timescale 1ns/1ps
`include "comm_otp_fault_map.svh"

module comm_otp_fault_status_test;
    import comm_otp_fault_pkg::*;
    logic clock = 1'h0, resetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0;
    wire logic awready, wready, bvalid, arready, rvalid, summary;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    power_mode_e power_mode = MODE_ACTIVE;
    host_events_s host_ev = '0;
    port_events_s lower_ev = '0, upper_ev = '0;
    logic frame_rx_done = 1'h0, frame_fault_bits = 1'h0;
    load_result_s load_res = '0;
    logic hw_rst_req = 1'h0;
    wire supervision_s lower_sup, upper_sup;
    logic lower_on = 1'h0, upper_on = 1'h0, tone_on = 1'h0;
    logic [7:0] hb_period = 8'h0A;
    int n_mismatch = 0, cmp_count = 0;
    localparam int HB_MAX = 20;

    always #10 clock = ~clock;

    comm_otp_fault_status #(.HB_MIN(4), .HB_MAX(HB_MAX))
        comm_otp_fault_status_inst (
        .clock(clock), .resetn(resetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .power_mode(power_mode), .host_ev(host_ev),
        .lower_ev(lower_ev), .upper_ev(upper_ev),
        .frame_rx_done(frame_rx_done),
        .frame_fault_bits(frame_fault_bits),
        .lower_sup(lower_sup), .upper_sup(upper_sup),
        .load_res(load_res), .hardware_reset_request(hw_rst_req),
        .comm_fault_summary(summary));

    stack_neighbour stack_neighbour_inst (
        .clock(clock), .resetn(resetn), .lower_on(lower_on),
        .upper_on(upper_on), .tone_on(tone_on), .hb_period(hb_period),
        .lower_sup(lower_sup), .upper_sup(upper_sup));

    // ----------------------------------------
    // bus and check helpers
    // ----------------------------------------
    task automatic tick();
        @(posedge clock);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        int n;
        tick();
        awaddr  <= {idx, 2'h0};
        wdata   <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        for (n = 0; n < 50; n++) begin
            tick();
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        bready <= 1'h0;
        chk("bresp", 32'h0, {30'h0, bresp});
        if (n == 50) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    task automatic rd(input logic [13:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        tick();
        araddr  <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready  <= 1'h1;
        for (n = 0; n < 50; n++) begin
            tick();
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        if (n == 50) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    task automatic rchk(input string nm, input logic [13:0] idx,
                        input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(idx, d, r);
        chk(nm, {24'h0, e}, d);
    endtask

    task automatic ld(input load_result_s v);
        load_res <= v;
        tick();
        load_res <= '0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // reset values, unmapped place
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rchk("host_uart", `IDX_HOST_UART, 8'h00);
        rchk("daisy_port", `IDX_DAISY_PORT, 8'h00);
        rchk("config_load", `IDX_CONFIG_LOAD, 8'h00);
        rd(14'h0001, d, r);
        chk("unmapped_resp", 32'h2, {30'h0, r});
        chk("unmapped_data", 32'h0, d);
        $display("test reset done");
    endtask

    task automatic t_host();
        host_events_s ev [9] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04,
                                 7'h04, 7'h02, 7'h02, 7'h01};
        power_mode_e md [9] = '{MODE_ACTIVE, MODE_ACTIVE, MODE_ACTIVE,
            MODE_SLEEP, MODE_ACTIVE, MODE_SLEEP, MODE_ACTIVE,
            MODE_SLEEP, MODE_ACTIVE};
        logic [7:0] ex [9] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h03,
                               8'h02, 8'h02, 8'h00, 8'h01};
        foreach (ex[i]) begin
            power_mode <= md[i];
            host_ev    <= ev[i];
            tick();
            host_ev    <= '0;
            rchk("host_uart", `IDX_HOST_UART, ex[i]);
            rchk("host_uart_again", `IDX_HOST_UART, ex[i]);
            wr(`IDX_CLEAR_CMD, 8'h01);
        end
        host_ev <= 7'h40;
        tick();
        host_ev <= '0;
        wr(`IDX_COMM_MASK, 8'h1F);
        chk("summary_masked", 32'h0, {31'h0, summary});
        wr(`IDX_COMM_MASK, 8'h1E);
        chk("summary_uart", 32'h1, {31'h0, summary});
        wr(`IDX_CLEAR_CMD, 8'h01);
        chk("summary_cleared", 32'h0, {31'h0, summary});
        wr(`IDX_COMM_MASK, 8'h00);
        $display("test host done");
    endtask

    task automatic t_port();
        lower_ev <= 4'h8;
        upper_ev <= 4'h1;
        tick();
        lower_ev <= 4'h6;
        upper_ev <= 4'h0;
        tick();
        lower_ev <= 4'h0;
        rchk("daisy_port", `IDX_DAISY_PORT, 8'hE1);
        wr(`IDX_CLEAR_CMD, 8'h01);
        rchk("daisy_port_kept", `IDX_DAISY_PORT, 8'hE1);
        wr(`IDX_CLEAR_CMD, 8'h02);
        rchk("daisy_port_clear", `IDX_DAISY_PORT, 8'h00);
        $display("test port done");
    endtask

    // only frames with fault bits set the flag
    task automatic t_stack();
        logic [31:0] d;
        logic [1:0]  r;
        for (int b = 0; b < 2; b++) begin
            frame_fault_bits <= b[0];
            frame_rx_done    <= 1'h1;
            tick();
            frame_rx_done    <= 1'h0;
            rd(`IDX_STACK_LINK, d, r);
            chk("stack_fault", {31'h0, b[0]}, {31'h0, d[3]});
        end
        wr(`IDX_CLEAR_CMD, 8'h10);
        rd(`IDX_STACK_LINK, d, r);
        chk("stack_fault_clear", 32'h0, {31'h0, d[3]});
        $display("test stack done");
    endtask

    task automatic t_heartbeat();
        lower_on <= 1'h1;
        wr(`IDX_LINK_CTRL, 8'h00);
        wr(`IDX_CLEAR_CMD, 8'h0C);
        repeat (3 * HB_MAX) tick();
        rchk("hb_steady", `IDX_STACK_LINK, 8'h00);
        wr(`IDX_LINK_CTRL, 8'h01);
        repeat (HB_MAX + 5) tick();
        rchk("hb_missing", `IDX_STACK_LINK, 8'h02);
        lower_on  <= 1'h0;
        upper_on  <= 1'h1;
        hb_period <= 8'h02;
        repeat (10) tick();
        wr(`IDX_CLEAR_CMD, 8'h04);
        repeat (10) tick();
        rchk("heartbeat_too_fast", `IDX_STACK_LINK, 8'h01);
        hb_period <= 8'h0A;
        tone_on   <= 1'h1;
        repeat (12) tick();
        wr(`IDX_CLEAR_CMD, 8'h0C);
        repeat (12) tick();
        rchk("tone_early", `IDX_STACK_LINK, 8'h05);
        tone_on  <= 1'h0;
        upper_on <= 1'h0;
        $display("test heartbeat done");
    endtask

    // load results, partial clears, hardware reset
    task automatic t_load();
        page_status_s pg [5] = '{5'h00, 5'h18, 5'h14, 5'h17, 5'h16};
        logic [7:0] ex [5] = '{8'h06, 8'h06, 8'h06, 8'h06, 8'h00};
        foreach (pg[i]) begin
            ld({1'h1, 4'h0, pg[i], pg[i], 2'h0});
            rchk("load_err", `IDX_CONFIG_LOAD, ex[i]);
            wr(`IDX_CLEAR_CMD, 8'h60);
            rchk("load_err_kept", `IDX_CONFIG_LOAD, ex[i]);
            hw_rst_req <= 1'h1;
            tick();
            hw_rst_req <= 1'h0;
            rchk("load_err_hw", `IDX_CONFIG_LOAD, 8'h00);
        end
        // every load error, good pages, overvoltage
        ld(17'h1FB5A);
        rchk("load_all", `IDX_CONFIG_LOAD, 8'h79);
        wr(`IDX_CLEAR_CMD, 8'h40);
        rchk("crc_clear", `IDX_CONFIG_LOAD, 8'h61);
        wr(`IDX_CLEAR_CMD, 8'h20);
        rchk("data_clear", `IDX_CONFIG_LOAD, 8'h01);
        ld(17'h00001);
        rchk("ov_reeval", `IDX_CONFIG_LOAD, 8'h00);
        $display("test load done");
    endtask

    initial begin
        repeat (12) tick();
        resetn <= 1'h1;
        t_reset();
        t_host();
        t_port();
        t_stack();
        t_heartbeat();
        t_load();
        wrap_up();
    end
endmodule
